// ### rhpsc_top.sv
// Root hub per-port status and change-flag logic with its command-code register access.
//
// Contract
// RULE_01: When the 10 ms port reset signalling ends the reset-done change flag is set, reads one, and a written one clears it.
// RULE_02: The over-current change flag only carries meaning when over-current is reported per port.
// RULE_03: Every change of the port over-current indicator sets the over-current change flag, cleared by writing one.
// RULE_04: The resume-done change flag is set only after the resume pulse, low-speed end of packet and 3 ms resync delay.
// RULE_05: The resume-done change flag is cleared automatically when the reset-done change flag becomes set.
// RULE_06: A hardware event that drops port enable sets the enable-lost change flag, cleared by writing one.
// RULE_07: Enable changes caused by software enable or disable commands never set the enable-lost change flag.
// RULE_08: Every attach or detach sets the attach change flag, cleared by writing one.
// RULE_09: A reset, enable or suspend command on a port with no device sets the attach change flag.
// RULE_10: On a port holding a fixed device the attach change flag is set only after a root hub reset.
// RULE_11: The speed bit reads one for a low-speed device and zero for a full-speed device.
// RULE_12: The low-speed indication is valid only while a device is attached, and reads zero otherwise.
// RULE_13: Writing one to the speed bit position turns port power off.
// RULE_14: A written zero leaves every change flag and command state unchanged.
// RULE_15: The reset-in-progress bit clears in the same cycle that the reset-done change flag sets.
// RULE_16: A status write made during a USB transaction takes effect only after the transaction completes.
// RULE_17: Every downstream port keeps its own independent flags and status.
`timescale 1ns/100ps
module rhpsc_top #(
    parameter int RESET_CYCLES = rhpsc_pkg::RESET_CYCLES,
    parameter int RESUME_CYCLES = rhpsc_pkg::RESUME_CYCLES,
    parameter int RESYNC_CYCLES = rhpsc_pkg::RESYNC_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic [31:0] i_wr_data,
    input wire logic i_transaction_busy,
    input wire logic i_per_port_overcurrent,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_fixed_device_mask,
    input wire logic i_hub_reset_done,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_attach_pin,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_slow_pin,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_overload_pin,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_port_error,
    output logic [31:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_wr_pending,
    output logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_port_power_on,
    output logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_reset_signalling,
    output logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_resume_signalling
);
    localparam int DOWNSTREAM_PORT_COUNT = rhpsc_pkg::DOWNSTREAM_PORT_COUNT;
    localparam int PW = rhpsc_pkg::PW;
    localparam int TW = rhpsc_pkg::TIMER_W;

    // ************************************************************
    // Code decoding
    // ************************************************************
    function automatic logic code_hit(input logic [7:0] code, input logic [7:0] base);
        logic [7:0] off;
        off = code - base;
        return (code >= base) && (off < 8'(DOWNSTREAM_PORT_COUNT));
    endfunction

    function automatic logic [PW-1:0] code_port(input logic [7:0] code, input logic [7:0] base);
        logic [7:0] off;
        off = code - base;
        return off[PW-1:0];
    endfunction

    // ************************************************************
    // Deferred write holding register
    // ************************************************************
    logic [31:0] pend_data;
    logic [PW-1:0] pend_port;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_word [DOWNSTREAM_PORT_COUNT];

    assign wr_hit = i_cmd_valid && code_hit(i_cmd_code, rhpsc_pkg::WR_CODE_BASE);
    assign rd_hit = i_cmd_valid && code_hit(i_cmd_code, rhpsc_pkg::RD_CODE_BASE);

    // Only one write is held; a second write while one waits is dropped and software sees o_wr_pending.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wr_pending <= 1'b0;
            pend_data <= 32'h0000_0000;
            pend_port <= '0;
        end else if (o_wr_pending) begin
            if (!i_transaction_busy) begin // see RULE_16
                o_wr_pending <= 1'b0;
            end
        end else if (wr_hit) begin
            o_wr_pending <= 1'b1;
            pend_data <= i_wr_data;
            pend_port <= code_port(i_cmd_code, rhpsc_pkg::WR_CODE_BASE);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= rhpsc_pkg::STATE_RESET_VALUE;
        end else begin
            o_rd_valid <= rd_hit;
            if (rd_hit) begin
                o_rd_data <= rd_word[code_port(i_cmd_code, rhpsc_pkg::RD_CODE_BASE)];
            end
        end
    end

    // ************************************************************
    // Per-port logic
    // ************************************************************
    genvar p;
    generate
        for (p = 0; p < DOWNSTREAM_PORT_COUNT; p++) begin : g_port
            rhpsc_pkg::rhpsc_seq_t st;
            logic [TW-1:0] tmr;
            logic att_sync;
            logic slow_sync;
            logic oc_sync;
            logic attached;
            logic enabled;
            logic suspended;
            logic overload;
            logic rst_prog;
            logic power;
            logic slow;
            logic resuming;
            logic att_chg;
            logic en_chg;
            logic res_chg;
            logic oc_chg;
            logic rst_chg;
            logic apply;
            logic [31:0] wd;
            logic next_attached;
            logic next_overload;
            logic attach_event;
            logic reset_done;
            logic resume_done;
            logic hw_drop;

            rhpsc_sync u_att (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_async(i_attach_pin[p]),
                .o_level(att_sync)
            );
            rhpsc_sync u_slow (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_async(i_slow_pin[p]),
                .o_level(slow_sync)
            );
            rhpsc_sync u_oc (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_async(i_overload_pin[p]),
                .o_level(oc_sync)
            );

            // Writes reach this port only when the transaction on the bus has finished.
            assign apply = o_wr_pending && !i_transaction_busy && (pend_port == PW'(p)); // see RULE_16 see RULE_17
            assign wd = apply ? pend_data : 32'h0000_0000; // see RULE_14
            assign next_attached = power && att_sync;
            assign next_overload = i_per_port_overcurrent && oc_sync; // see RULE_02
            assign attach_event = attached != next_attached;
            assign reset_done = (st == rhpsc_pkg::ST_PORT_RESET) && (tmr == '0) && next_attached;
            assign resume_done = (st == rhpsc_pkg::ST_RESYNC) && (tmr == '0) && next_attached;
            assign hw_drop = enabled && (!next_attached || next_overload || i_port_error[p]); // see RULE_06

            // ****************************************************
            // Reset and resume sequencer
            // ****************************************************
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    st <= rhpsc_pkg::ST_IDLE;
                    tmr <= '0;
                end else if (!next_attached) begin
                    st <= rhpsc_pkg::ST_IDLE;
                    tmr <= '0;
                end else begin
                    unique case (st)
                        rhpsc_pkg::ST_IDLE: begin
                            if (wd[rhpsc_pkg::W_SET_RESET] && attached) begin
                                st <= rhpsc_pkg::ST_PORT_RESET;
                                tmr <= TW'(RESET_CYCLES - 1); // see RULE_01
                            end else if (wd[rhpsc_pkg::W_CLR_SUSPEND] && suspended) begin
                                st <= rhpsc_pkg::ST_RESUME;
                                tmr <= TW'(RESUME_CYCLES - 1);
                            end
                        end
                        rhpsc_pkg::ST_RESUME: begin
                            if (tmr == '0) begin
                                st <= rhpsc_pkg::ST_EOP;
                                tmr <= TW'(rhpsc_pkg::EOP_CYCLES - 1);
                            end else begin
                                tmr <= tmr - 1'b1;
                            end
                        end
                        rhpsc_pkg::ST_EOP: begin
                            if (tmr == '0) begin
                                st <= rhpsc_pkg::ST_RESYNC;
                                tmr <= TW'(RESYNC_CYCLES - 1); // see RULE_04
                            end else begin
                                tmr <= tmr - 1'b1;
                            end
                        end
                        rhpsc_pkg::ST_RESYNC, rhpsc_pkg::ST_PORT_RESET: begin
                            if (tmr == '0) begin
                                st <= rhpsc_pkg::ST_IDLE;
                            end else begin
                                tmr <= tmr - 1'b1;
                            end
                        end
                        default: begin
                            st <= rhpsc_pkg::ST_IDLE;
                            tmr <= '0;
                        end
                    endcase
                end
            end

            // ****************************************************
            // Port status bits
            // ****************************************************
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    attached <= 1'b0;
                    power <= 1'b0;
                    enabled <= 1'b0;
                    suspended <= 1'b0;
                    overload <= 1'b0;
                    rst_prog <= 1'b0;
                    resuming <= 1'b0;
                    slow <= 1'b0;
                end else begin
                    attached <= next_attached;
                    overload <= next_overload;
                    slow <= slow_sync;
                    // Losing power also drops attach, enable, suspend and reset via next_attached.
                    if (next_overload || wd[rhpsc_pkg::W_CLR_POWER]) begin // see RULE_13
                        power <= 1'b0;
                    end else if (wd[rhpsc_pkg::W_SET_POWER]) begin
                        power <= 1'b1;
                    end
                    if (hw_drop) begin
                        enabled <= 1'b0;
                    end else if (reset_done) begin
                        enabled <= 1'b1;
                    end else if (wd[rhpsc_pkg::W_CLR_ENABLE]) begin
                        enabled <= 1'b0;
                    end else if (wd[rhpsc_pkg::W_SET_ENABLE] && attached) begin
                        enabled <= 1'b1;
                    end
                    if (!next_attached || reset_done || resume_done) begin
                        suspended <= 1'b0;
                    end else if (wd[rhpsc_pkg::W_SET_SUSPEND] && enabled) begin
                        suspended <= 1'b1;
                    end
                    if (!next_attached || reset_done) begin // see RULE_15
                        rst_prog <= 1'b0;
                    end else if (wd[rhpsc_pkg::W_SET_RESET] && attached && st == rhpsc_pkg::ST_IDLE) begin
                        rst_prog <= 1'b1;
                    end
                    if (!next_attached || (st == rhpsc_pkg::ST_RESUME && tmr == '0)) begin
                        resuming <= 1'b0;
                    end else if (wd[rhpsc_pkg::W_CLR_SUSPEND] && suspended && st == rhpsc_pkg::ST_IDLE) begin
                        resuming <= 1'b1;
                    end
                end
            end

            // ****************************************************
            // Change flags; a hardware set always beats a software clear
            // ****************************************************
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    att_chg <= 1'b0;
                    en_chg <= 1'b0;
                    res_chg <= 1'b0;
                    oc_chg <= 1'b0;
                    rst_chg <= 1'b0;
                end else begin
                    if ((!i_fixed_device_mask[p] && attach_event) // see RULE_08
                        || (!attached && (wd[rhpsc_pkg::W_SET_RESET] || wd[rhpsc_pkg::W_SET_ENABLE]
                            || wd[rhpsc_pkg::W_SET_SUSPEND])) // see RULE_09
                        || (i_fixed_device_mask[p] && i_hub_reset_done && next_attached)) begin // see RULE_10
                        att_chg <= 1'b1;
                    end else if (wd[rhpsc_pkg::B_ATT_CHG]) begin
                        att_chg <= 1'b0;
                    end
                    // Software disable is not a hardware drop, so it never sets this flag.
                    if (hw_drop) begin // see RULE_07
                        en_chg <= 1'b1;
                    end else if (wd[rhpsc_pkg::B_EN_CHG]) begin
                        en_chg <= 1'b0;
                    end
                    if (resume_done) begin // see RULE_04
                        res_chg <= 1'b1;
                    end else if (reset_done || wd[rhpsc_pkg::B_RES_CHG]) begin // see RULE_05
                        res_chg <= 1'b0;
                    end
                    if (next_overload != overload) begin // see RULE_03
                        oc_chg <= 1'b1;
                    end else if (wd[rhpsc_pkg::B_OC_CHG]) begin
                        oc_chg <= 1'b0;
                    end
                    if (reset_done) begin // see RULE_01
                        rst_chg <= 1'b1;
                    end else if (wd[rhpsc_pkg::B_RST_CHG]) begin
                        rst_chg <= 1'b0;
                    end
                end
            end

            // ****************************************************
            // Read word and pins
            // ****************************************************
            always_comb begin
                rd_word[p] = 32'h0000_0000;
                rd_word[p][rhpsc_pkg::B_ATTACHED] = attached;
                rd_word[p][rhpsc_pkg::B_ENABLED] = enabled;
                rd_word[p][rhpsc_pkg::B_SUSPENDED] = suspended;
                rd_word[p][rhpsc_pkg::B_OVERLOAD] = overload;
                rd_word[p][rhpsc_pkg::B_RESET] = rst_prog;
                rd_word[p][rhpsc_pkg::B_POWER] = power;
                rd_word[p][rhpsc_pkg::B_SLOW] = slow && attached; // see RULE_11 see RULE_12
                rd_word[p][rhpsc_pkg::B_ATT_CHG] = att_chg;
                rd_word[p][rhpsc_pkg::B_EN_CHG] = en_chg;
                rd_word[p][rhpsc_pkg::B_RES_CHG] = res_chg;
                rd_word[p][rhpsc_pkg::B_OC_CHG] = oc_chg;
                rd_word[p][rhpsc_pkg::B_RST_CHG] = rst_chg;
            end

            assign o_port_power_on[p] = power;
            assign o_reset_signalling[p] = rst_prog;
            assign o_resume_signalling[p] = resuming;
        end
    endgenerate
endmodule // rhpsc_top

// ### rhpsc_pkg.sv
// Constants, bit positions and sequencer states for the root hub port status-change logic.
package rhpsc_pkg;

    // ************************************************************
    // Port count and clock
    // ************************************************************
    localparam int DOWNSTREAM_PORT_COUNT = 2;
    localparam int PW = 1;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 20;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // ************************************************************
    // Timing, each time in its own unit and the derived cycle count
    // ************************************************************
    localparam int RESET_MS = 10;
    localparam int RESET_CYCLES = RESET_MS * CYC_PER_MS;
    localparam int RESUME_MS = 20;
    localparam int RESUME_CYCLES = RESUME_MS * CYC_PER_MS;
    localparam int LS_EOP_NS = 1334;
    localparam int EOP_CYCLES = (LS_EOP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESYNC_MS = 3;
    localparam int RESYNC_CYCLES = RESYNC_MS * CYC_PER_MS;
    localparam int TIMER_W = 20;

    // ************************************************************
    // Register access codes
    // ************************************************************
    localparam logic [7:0] RD_CODE_BASE = 8'h15;
    localparam logic [7:0] WR_CODE_BASE = 8'h95;
    localparam logic [31:0] STATE_RESET_VALUE = 32'h0000_0000;

    // ************************************************************
    // Read field positions
    // ************************************************************
    localparam int B_ATTACHED = 0;
    localparam int B_ENABLED = 1;
    localparam int B_SUSPENDED = 2;
    localparam int B_OVERLOAD = 3;
    localparam int B_RESET = 4;
    localparam int B_POWER = 8;
    localparam int B_SLOW = 9;
    localparam int B_ATT_CHG = 16;
    localparam int B_EN_CHG = 17;
    localparam int B_RES_CHG = 18;
    localparam int B_OC_CHG = 19;
    localparam int B_RST_CHG = 20;

    // ************************************************************
    // Write command positions
    // ************************************************************
    localparam int W_CLR_ENABLE = 0;
    localparam int W_SET_ENABLE = 1;
    localparam int W_SET_SUSPEND = 2;
    localparam int W_CLR_SUSPEND = 3;
    localparam int W_SET_RESET = 4;
    localparam int W_SET_POWER = 8;
    localparam int W_CLR_POWER = 9;

    // ************************************************************
    // Port sequencer states, Gray coded along the resume path
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RESUME = 3'h1,
        ST_EOP = 3'h3,
        ST_RESYNC = 3'h2,
        ST_PORT_RESET = 3'h6
    } rhpsc_seq_t;

endpackage

// ### rhpsc_sync.sv
// Three-stage input synchroniser that accepts a level once the last two stages agree.
`timescale 1ns/100ps
module rhpsc_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_level
);
    logic s1;
    logic s2;
    logic s3;

    // The first stage is read only by the second; the agreement check looks at stages two and three.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // rhpsc_sync

// ### rhpsc_props.sv
// Port-level assertions for the root hub port status-change block.
`timescale 1ns/100ps
module rhpsc_props #(
    parameter int RESET_CYCLES = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire logic [31:0] i_wr_data,
    input wire logic i_transaction_busy,
    input wire logic [31:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_wr_pending,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_port_power_on,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_reset_signalling
);
    wire logic rd_hit = i_cmd_valid && (i_cmd_code == 8'h15 || i_cmd_code == 8'h16);
    wire logic wr_hit = i_cmd_valid && (i_cmd_code == 8'h95 || i_cmd_code == 8'h96);
    logic [31:0] wr_data_q;
    logic wr_port_q;
    int rst_cnt;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // A write offered while one is pending is dropped, so only accepted words are kept.
    always_ff @(posedge i_clk) begin
        if (wr_hit && !o_wr_pending) begin
            wr_data_q <= i_wr_data;
            wr_port_q <= i_cmd_code[1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !o_reset_signalling[0]) begin
            rst_cnt <= 0;
        end else begin
            rst_cnt <= rst_cnt + 1;
        end
    end

    a_read_answer: assert property (rd_hit |=> o_rd_valid)
        else $error("read code not answered next cycle");
    a_read_quiet: assert property (!rd_hit |=> !o_rd_valid && $stable(o_rd_data))
        else $error("read answer without read code");
    a_write_taken: assert property (wr_hit && !o_wr_pending |=> o_wr_pending)
        else $error("write not taken");
    a_write_deferred: assert property (o_wr_pending && i_transaction_busy |=> o_wr_pending)
        else $error("write applied during transaction");
    a_write_applied: assert property (o_wr_pending && !i_transaction_busy |=> !o_wr_pending)
        else $error("write not applied once bus idle");
    a_power_clear: assert property (o_wr_pending && !i_transaction_busy && wr_data_q[9] && !wr_data_q[8]
        |=> !o_port_power_on[wr_port_q])
        else $error("power-off command left power on");
    a_slow_masked: assert property (o_rd_valid && !o_rd_data[0] |-> !o_rd_data[9])
        else $error("slow device shown without device");
    a_reset_length: assert property ($fell(o_reset_signalling[0]) && o_port_power_on[0]
        |-> rst_cnt >= RESET_CYCLES - 1 && rst_cnt <= RESET_CYCLES + 1)
        else $error("port reset signalling has wrong length");
endmodule // rhpsc_props

bind rhpsc_top rhpsc_props #(.RESET_CYCLES(RESET_CYCLES)) rhpsc_props_inst (.i_clk, .i_rst_n, .i_cmd_valid,
    .i_cmd_code, .i_wr_data, .i_transaction_busy, .o_rd_data, .o_rd_valid, .o_wr_pending, .o_port_power_on,
    .o_reset_signalling);

// ### rhpsc_usb_dev.sv
// Behavioural model of the USB devices plugged into the downstream ports.
`timescale 1ns/100ps
module rhpsc_usb_dev (
    input wire logic i_clk,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_plug,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_low,
    input wire logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] i_fault,
    output logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_attach_pin,
    output logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_slow_pin,
    output logic [rhpsc_pkg::DOWNSTREAM_PORT_COUNT-1:0] o_overload_pin
);
    logic toggle;

    // An empty port has nothing holding the speed line, so it wanders instead of keeping a level.
    initial toggle = 1'b0;
    always @(posedge i_clk) toggle <= ~toggle;

    assign o_attach_pin = i_plug;
    assign o_slow_pin = (i_plug & i_low) | (~i_plug & {rhpsc_pkg::DOWNSTREAM_PORT_COUNT{toggle}});
    assign o_overload_pin = i_fault;
endmodule // rhpsc_usb_dev

// ### rhpsc_test.sv
// Self-checking testbench for the root hub port status-change block.
`timescale 1ns/100ps
module rhpsc_test;
    localparam int RST_CYC = 20;
    localparam logic [31:0] F = 32'hffff_ffff;
    logic i_clk, i_rst_n, i_cmd_valid, i_transaction_busy, i_per_port_overcurrent, i_hub_reset_done;
    logic [7:0] i_cmd_code;
    logic [31:0] i_wr_data, o_rd_data;
    logic [1:0] i_fixed_device_mask, i_port_error, i_attach_pin, i_slow_pin, i_overload_pin, plug, low, fault;
    logic o_rd_valid, o_wr_pending;
    logic [1:0] o_port_power_on, o_reset_signalling, o_resume_signalling;
    int errors = 0;
    int checks_done = 0;

    rhpsc_top #(.RESET_CYCLES(RST_CYC), .RESUME_CYCLES(10), .RESYNC_CYCLES(8)) rhpsc_top_inst (.i_clk, .i_rst_n,
        .i_cmd_valid, .i_cmd_code, .i_wr_data, .i_transaction_busy, .i_per_port_overcurrent, .i_fixed_device_mask,
        .i_hub_reset_done, .i_attach_pin, .i_slow_pin, .i_overload_pin, .i_port_error, .o_rd_data, .o_rd_valid,
        .o_wr_pending, .o_port_power_on, .o_reset_signalling, .o_resume_signalling);
    rhpsc_usb_dev rhpsc_usb_dev_inst (.i_clk, .i_plug(plug), .i_low(low), .i_fault(fault),
        .o_attach_pin(i_attach_pin), .o_slow_pin(i_slow_pin), .o_overload_pin(i_overload_pin));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic end_of_test;
        $display("Mismatches %0d, comparisons %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask

    task automatic access(input logic [7:0] code, input logic [31:0] data);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_code <= code;
        i_wr_data <= data;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic p, input logic [31:0] mask, input logic [31:0] exp);
        access(rhpsc_pkg::RD_CODE_BASE + {7'h00, p}, 32'h0000_0000);
        check(o_rd_valid === 1'b1 && (o_rd_data & mask) === exp, "port status read mismatch");
    endtask

    // Effects show one edge after the write is taken when the bus is idle; two spare edges are allowed.
    task automatic wr(input logic p, input logic [31:0] data);
        access(rhpsc_pkg::WR_CODE_BASE + {7'h00, p}, data);
        repeat (3) @(posedge i_clk);
    endtask

    initial begin
        repeat (3000) @(posedge i_clk);
        errors++;
        end_of_test();
    end

    initial begin
        {i_rst_n, i_cmd_valid, i_transaction_busy, i_per_port_overcurrent, i_hub_reset_done} = 5'h00;
        {i_cmd_code, i_wr_data, i_fixed_device_mask, i_port_error, plug, low, fault} = 50'h0;
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(0, F, 32'h0000_0000);
        access(8'h17, 32'h0000_0000);
        check(o_rd_valid === 1'b0, "unmapped code answered");
        wr(0, 32'h0000_0100);
        plug[0] <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(0, F, 32'h0001_0101);
        wr(0, 32'h0000_0000);
        rd(0, F, 32'h0001_0101);
        wr(0, 32'h0001_0000);
        rd(0, F, 32'h0000_0101);
        wr(1, 32'h0000_0002);
        rd(1, F, 32'h0001_0000);
        rd(0, F, 32'h0000_0101);
        wr(0, 32'h0000_0010);
        rd(0, F, 32'h0000_0111);
        repeat (RST_CYC) @(posedge i_clk);
        rd(0, F, 32'h0010_0103);
        wr(0, 32'h0010_0000);
        wr(0, 32'h0000_0001);
        rd(0, F, 32'h0000_0101);
        wr(0, 32'h0000_0002);
        rd(0, F, 32'h0000_0103);
        wr(0, 32'h0000_0004);
        wr(0, 32'h0000_0008);
        check(o_resume_signalling === 2'b01, "resume pulse not driven");
        repeat (90) @(posedge i_clk);
        rd(0, F, 32'h0004_0103);
        wr(0, 32'h0000_0010);
        repeat (RST_CYC) @(posedge i_clk);
        rd(0, F, 32'h0010_0103);
        wr(0, 32'h0010_0000);
        i_port_error <= 2'b01;
        @(posedge i_clk);
        i_port_error <= 2'b00;
        repeat (2) @(posedge i_clk);
        rd(0, F, 32'h0002_0101);
        i_transaction_busy <= 1'b1;
        access(8'h95, 32'h0002_0000);
        repeat (5) @(posedge i_clk);
        rd(0, 32'h0002_0000, 32'h0002_0000);
        i_transaction_busy <= 1'b0;
        repeat (3) @(posedge i_clk);
        rd(0, F, 32'h0000_0101);
        wr(1, 32'h0001_0000);
        wr(1, 32'h0000_0100);
        plug[1] <= 1'b1;
        low[1] <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(1, F, 32'h0001_0301);
        wr(1, 32'h0001_0000);
        plug[1] <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(1, F, 32'h0001_0100);
        fault[1] <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(1, 32'h0008_0008, 32'h0000_0000);
        fault[1] <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_per_port_overcurrent <= 1'b1;
        fault[1] <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(1, 32'h0008_0008, 32'h0008_0008);
        wr(1, 32'h0008_0000);
        fault[1] <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd(1, 32'h0008_0008, 32'h0008_0000);
        i_fixed_device_mask <= 2'b01;
        i_hub_reset_done <= 1'b1;
        @(posedge i_clk);
        i_hub_reset_done <= 1'b0;
        rd(0, 32'h0001_0000, 32'h0001_0000);
        wr(0, 32'h0000_0200);
        rd(0, 32'h0000_0100, 32'h0000_0000);
        end_of_test();
    end
endmodule // rhpsc_test
